// file: hw/raid_xor_map.vh
// register map, field positions, reset values and sizes of the parity accumulator
// assumes 32-bit software registers on word-aligned byte addresses
`ifndef RAID_XOR_MAP_VH
`define RAID_XOR_MAP_VH

// register byte offsets
`define OFF_ACCEL_CTRL 8'h00
`define OFF_DESC_CTRL 8'h04
`define OFF_BYTE_COUNT 8'h08
`define OFF_SRC1 8'h10
`define OFF_SRC2 8'h14
`define OFF_SRC3 8'h18
`define OFF_SRC4 8'h1c
`define OFF_DEST 8'h20
`define OFF_COEF 8'h24
`define OFF_STATUS 8'h28
`define OFF_REMAIN 8'h2c

// accelerator control fields
`define ACC_START_BIT 0
`define ACC_PQ_BIT 1
`define ACC_BUF512_BIT 2

// descriptor control word fields
`define DC_FILL_BIT 0
`define DC_DWE_BIT 1
`define DC_NSRC_LSB 2
`define DC_NSRC_MSB 3

// status fields
`define ST_BUSY_BIT 0
`define ST_DONE_BIT 1

// reset values
`define RST_ACCEL_CTRL 32'h0000_0000
`define RST_DESC_CTRL 32'h0000_000f
`define RST_WORD 32'h0000_0000

// store queue geometry
`define BUF_BYTES_LARGE 11'h400
`define BUF_BYTES_SMALL 11'h200
`define SQ_UNIT_BYTES 4'h8
`define SQ_DEPTH 128
`define SQ_AW 7
`define BYTE_COUNT_W 24

// galois field reduction, x^8+x^4+x^3+x^2+1 without the x^8 term
`define GF_POLY_LOW 8'h1d
`define GF_ORDER 9'h0ff

`endif

// file: hw/gf_mul_lane.v
// one byte lane of the galois field multiplier, built from log and inverse log
// assumes purely combinational use; the coefficient is shared by all lanes
`timescale 1ns/10ps
`include "raid_xor_map.vh"

module gf_mul_lane (
  input wire [7:0] dataIn,
  input wire [7:0] coef,
  output reg [7:0] product
);

  // inverse log: alpha raised to e, stepping through the field
  function [7:0] ilogF;
    input [7:0] e;
    integer k;
    reg [7:0] a;
    begin
      a = 8'h01;
      for (k = 0; k < 255; k = k + 1) begin
        if (k < e) begin
          a = {a[6:0], 1'b0} ^ (a[7] ? `GF_POLY_LOW : 8'h00);
        end
      end
      ilogF = a;
    end
  endfunction

  // log: exponent whose power equals v; zero has none and maps to zero
  function [7:0] logF;
    input [7:0] v;
    integer k;
    reg [7:0] a;
    reg [7:0] r;
    begin
      a = 8'h01;
      r = 8'h00;
      for (k = 0; k < 255; k = k + 1) begin
        if (a == v) begin
          r = k[7:0];
        end
        a = {a[6:0], 1'b0} ^ (a[7] ? `GF_POLY_LOW : 8'h00);
      end
      logF = r;
    end
  endfunction

  reg [8:0] logSum;

  always @* begin
    logSum = {1'b0, logF(dataIn)} + {1'b0, logF(coef)};
    if (logSum >= `GF_ORDER) begin
      logSum = logSum - `GF_ORDER;
    end
    if (dataIn == 8'h00 || coef == 8'h00) begin
      product = 8'h00;
    end else begin
      product = ilogF(logSum[7:0]);
    end
  end

endmodule // gf_mul_lane

// file: hw/store_queue_mem.v
// store queue: 128 words of 8 bytes, one write and one registered read port
// assumes reads and writes in the same cycle target different words
`timescale 1ns/10ps
`include "raid_xor_map.vh"

module store_queue_mem (
  input wire sys_clk,
  input wire wrEn,
  input wire [`SQ_AW-1:0] wrAddr,
  input wire [63:0] wrData,
  input wire rdEn,
  input wire [`SQ_AW-1:0] rdAddr,
  output reg [63:0] rdData
);

  reg [63:0] mem [0:`SQ_DEPTH-1];

  always @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end

endmodule // store_queue_mem

// file: hw/raid_xor_gf_accumulator.v
// parity accumulator datapath: reads up to four sources, folds them into the
// store queue by xor (optionally after a gf multiply) and writes the result out
// assumes local memory answers each held request with one memAck pulse
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "raid_xor_map.vh"

// Summary of operation
// - direct-fill first source loads queue without xor
// - buffer size 1KB or 512B by control bit 2
// - xor-command first source xors with queue contents
// - count above buffer: pass per buffer, repeat
// - eight-byte units read in ascending order
// - xor result overwrites same queue position
// - sources taken first to fourth against queue
// - write enable set: queue written to destination
// - write enable clear: result stays in queue
// - write enable clear: only first buffer processed
// - engine masters reads and writes, xor inline
// - pq mode multiplies before accumulating
// - byte multiplier replicated on every lane, one coefficient
// - multiplier uses log and inverse log tables
// - log table maps 01 to 00, 02 to 01
// - inverse log maps 00 to 01, 08 to 1d
// - field polynomial is x^8+x^4+x^3+x^2+1
// - pq mode global, not per descriptor
module raid_xor_gf_accumulator (
  input wire sys_clk,
  input wire rstn,
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdataFf,
  output reg memRdFf,
  output reg memWrFf,
  output reg [31:0] memAddrFf,
  output reg [63:0] memWdataFf,
  input wire memAck,
  input wire [63:0] memRdata,
  output reg busyFf,
  output reg doneFf
);

  localparam S_IDLE = 3'd0;
  localparam S_SRC_REQ = 3'd1;
  localparam S_SRC_WAIT = 3'd2;
  localparam S_DST_RD = 3'd3;
  localparam S_DST_REQ = 3'd4;
  localparam S_DST_WAIT = 3'd5;
  localparam S_NEXT = 3'd6;

  // reset release through two flops
  reg [1:0] rstSyncFf;
  wire rstnSync;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstSyncFf <= 2'b00;
    end else begin
      rstSyncFf <= {rstSyncFf[0], 1'b1};
    end
  end

  assign rstnSync = rstSyncFf[1];

  // software registers
  reg pqModeFf;
  reg buf512Ff;
  reg fillCmdFf;
  reg dweFf;
  reg [1:0] srcLastFf;
  reg [`BYTE_COUNT_W-1:0] byteCountFf;
  reg [31:0] srcPtrFf [0:3];
  reg [31:0] destPtrFf;
  reg [31:0] coefFf;
  reg startFf;

  // engine state
  reg [2:0] stateFf;
  reg [1:0] srcIdxFf;
  reg [`SQ_AW-1:0] unitFf;
  reg [`BYTE_COUNT_W-1:0] remainFf;
  reg [`BYTE_COUNT_W-1:0] bufBaseFf;
  reg runFillFf;
  reg runDweFf;
  reg runPqFf;
  reg [10:0] runBufFf;

  // pass geometry
  wire [`BYTE_COUNT_W-1:0] bufBytesW;
  wire [`BYTE_COUNT_W-1:0] passBytes;
  wire [`BYTE_COUNT_W-1:0] passRound;
  wire [`SQ_AW-1:0] lastUnit;
  wire lastPass;
  wire [`BYTE_COUNT_W-1:0] unitOffset;
  wire [`BYTE_COUNT_W-1:0] bufAdvance;

  assign bufBytesW = {{(`BYTE_COUNT_W-11){1'b0}}, runBufFf};
  assign passBytes = (remainFf < bufBytesW) ? remainFf : bufBytesW;
  assign passRound = passBytes + 24'h000007;
  assign lastUnit = passRound[`SQ_AW+2:3] - 7'h01;
  assign lastPass = (remainFf == passBytes);
  assign unitOffset = {{(`BYTE_COUNT_W-`SQ_AW-3){1'b0}}, unitFf, 3'b000};
  assign bufAdvance = bufBaseFf + bufBytesW;

  // coefficient for the current source
  reg [7:0] curCoef;

  always @* begin
    case (srcIdxFf)
      2'd0: curCoef = coefFf[7:0];
      2'd1: curCoef = coefFf[15:8];
      2'd2: curCoef = coefFf[23:16];
      default: curCoef = coefFf[31:24];
    endcase
  end

  // gf multiply on every byte lane, same coefficient on all lanes
  wire [63:0] gfData;
  genvar lane;

  generate
    for (lane = 0; lane < 8; lane = lane + 1) begin : gLane
      gf_mul_lane uLane (
        .dataIn(memRdata[lane*8 +: 8]),
        .coef(curCoef),
        .product(gfData[lane*8 +: 8])
      );
    end
  endgenerate

  // store queue access
  wire [63:0] sqRdata;
  wire [63:0] srcData;
  wire [63:0] sqWrData;
  wire sqWrEn;
  wire sqRdEn;
  wire fillNow;

  assign srcData = runPqFf ? gfData : memRdata;
  assign fillNow = runFillFf && (srcIdxFf == 2'd0);
  // xor applied on the fly as each unit arrives from memory
  assign sqWrData = fillNow ? srcData : (sqRdata ^ srcData);
  assign sqWrEn = (stateFf == S_SRC_WAIT) && memAck;
  // the queue word is fetched one state ahead so it is settled when memAck lands
  assign sqRdEn = (stateFf == S_SRC_REQ) || (stateFf == S_DST_RD);

  store_queue_mem uQueue (
    .sys_clk(sys_clk),
    .wrEn(sqWrEn),
    .wrAddr(unitFf),
    .wrData(sqWrData),
    .rdEn(sqRdEn),
    .rdAddr(unitFf),
    .rdData(sqRdata)
  );

  wire regWrAcc;
  wire regWrStatus;

  assign regWrAcc = regWr && (regAddr == `OFF_ACCEL_CTRL);
  assign regWrStatus = regWr && (regAddr == `OFF_STATUS);

  // register writes; descriptor registers frozen while busy
  always @(posedge sys_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      pqModeFf <= 1'b0;
      buf512Ff <= 1'b0;
      fillCmdFf <= 1'b1;
      dweFf <= 1'b1;
      srcLastFf <= 2'd3;
      byteCountFf <= 24'h000000;
      srcPtrFf[0] <= `RST_WORD;
      srcPtrFf[1] <= `RST_WORD;
      srcPtrFf[2] <= `RST_WORD;
      srcPtrFf[3] <= `RST_WORD;
      destPtrFf <= `RST_WORD;
      coefFf <= `RST_WORD;
      startFf <= 1'b0;
    end else begin
      // start is a one-cycle pulse and is dropped while a descriptor runs
      startFf <= regWrAcc && regWdata[`ACC_START_BIT] && !busyFf;
      if (regWrAcc) begin
        pqModeFf <= regWdata[`ACC_PQ_BIT];
        buf512Ff <= regWdata[`ACC_BUF512_BIT];
      end
      if (regWr && !busyFf) begin
        case (regAddr)
          `OFF_DESC_CTRL: begin
            fillCmdFf <= regWdata[`DC_FILL_BIT];
            dweFf <= regWdata[`DC_DWE_BIT];
            srcLastFf <= regWdata[`DC_NSRC_MSB:`DC_NSRC_LSB];
          end
          `OFF_BYTE_COUNT: byteCountFf <= regWdata[`BYTE_COUNT_W-1:0];
          `OFF_SRC1: srcPtrFf[0] <= regWdata;
          `OFF_SRC2: srcPtrFf[1] <= regWdata;
          `OFF_SRC3: srcPtrFf[2] <= regWdata;
          `OFF_SRC4: srcPtrFf[3] <= regWdata;
          `OFF_DEST: destPtrFf <= regWdata;
          `OFF_COEF: coefFf <= regWdata;
          default: begin
          end
        endcase
      end
    end
  end

  // register reads, data one cycle after the strobe
  always @(posedge sys_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      regRdataFf <= 32'h00000000;
    end else if (regRd) begin
      case (regAddr)
        `OFF_ACCEL_CTRL: regRdataFf <= {29'h0, buf512Ff, pqModeFf, 1'b0};
        `OFF_DESC_CTRL: regRdataFf <= {28'h0, srcLastFf, dweFf, fillCmdFf};
        `OFF_BYTE_COUNT: regRdataFf <= {8'h00, byteCountFf};
        `OFF_SRC1: regRdataFf <= srcPtrFf[0];
        `OFF_SRC2: regRdataFf <= srcPtrFf[1];
        `OFF_SRC3: regRdataFf <= srcPtrFf[2];
        `OFF_SRC4: regRdataFf <= srcPtrFf[3];
        `OFF_DEST: regRdataFf <= destPtrFf;
        `OFF_COEF: regRdataFf <= coefFf;
        `OFF_STATUS: regRdataFf <= {30'h0, doneFf, busyFf};
        `OFF_REMAIN: regRdataFf <= {8'h00, remainFf};
        default: regRdataFf <= 32'h00000000;
      endcase
    end else begin
      regRdataFf <= 32'h00000000;
    end
  end

  // engine sequencer
  always @(posedge sys_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      stateFf <= S_IDLE;
      srcIdxFf <= 2'd0;
      unitFf <= 7'h00;
      remainFf <= 24'h000000;
      bufBaseFf <= 24'h000000;
      runFillFf <= 1'b0;
      runDweFf <= 1'b0;
      runPqFf <= 1'b0;
      runBufFf <= `BUF_BYTES_LARGE;
      memRdFf <= 1'b0;
      memWrFf <= 1'b0;
      memAddrFf <= 32'h00000000;
      memWdataFf <= 64'h0000000000000000;
      busyFf <= 1'b0;
      doneFf <= 1'b0;
    end else begin
      // done is sticky; a completion in the clearing cycle wins
      if (regWrStatus && regWdata[`ST_DONE_BIT]) begin
        doneFf <= 1'b0;
      end
      case (stateFf)
        S_IDLE: begin
          if (startFf) begin
            runFillFf <= fillCmdFf;
            runDweFf <= dweFf;
            runPqFf <= pqModeFf;
            runBufFf <= buf512Ff ? `BUF_BYTES_SMALL : `BUF_BYTES_LARGE;
            remainFf <= byteCountFf;
            bufBaseFf <= 24'h000000;
            srcIdxFf <= 2'd0;
            unitFf <= 7'h00;
            if (byteCountFf == 24'h000000) begin
              doneFf <= 1'b1;
            end else begin
              busyFf <= 1'b1;
              stateFf <= S_SRC_REQ;
            end
          end
        end
        S_SRC_REQ: begin
          memRdFf <= 1'b1;
          memAddrFf <= srcPtrFf[srcIdxFf] + {8'h00, bufBaseFf + unitOffset};
          stateFf <= S_SRC_WAIT;
        end
        S_SRC_WAIT: begin
          if (memAck) begin
            memRdFf <= 1'b0;
            if (unitFf == lastUnit) begin
              unitFf <= 7'h00;
              if (srcIdxFf == srcLastFf) begin
                srcIdxFf <= 2'd0;
                stateFf <= runDweFf ? S_DST_RD : S_NEXT;
              end else begin
                srcIdxFf <= srcIdxFf + 2'd1;
                stateFf <= S_SRC_REQ;
              end
            end else begin
              unitFf <= unitFf + 7'h01;
              stateFf <= S_SRC_REQ;
            end
          end
        end
        S_DST_RD: begin
          // spare cycle lets the registered queue read settle before the write
          stateFf <= S_DST_REQ;
        end
        S_DST_REQ: begin
          memWrFf <= 1'b1;
          memWdataFf <= sqRdata;
          memAddrFf <= destPtrFf + {8'h00, bufBaseFf + unitOffset};
          stateFf <= S_DST_WAIT;
        end
        S_DST_WAIT: begin
          if (memAck) begin
            memWrFf <= 1'b0;
            if (unitFf == lastUnit) begin
              unitFf <= 7'h00;
              stateFf <= S_NEXT;
            end else begin
              unitFf <= unitFf + 7'h01;
              stateFf <= S_DST_RD;
            end
          end
        end
        S_NEXT: begin
          // the finished pass comes off the count in this cycle; the decision still sees the count before it
          remainFf <= remainFf - passBytes;
          if (lastPass || !runDweFf) begin
            busyFf <= 1'b0;
            doneFf <= 1'b1;
            stateFf <= S_IDLE;
          end else begin
            bufBaseFf <= bufAdvance;
            stateFf <= S_SRC_REQ;
          end
        end
        default: begin
          stateFf <= S_IDLE;
        end
      endcase
    end
  end

endmodule // raid_xor_gf_accumulator

// file: test/raid_xor_monitor.sv
// port checker for the parity accumulator: memory handshake, start, done, read port
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
`include "raid_xor_map.vh"
module raid_xor_monitor (
  input wire sys_clk,
  input wire rstn,
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  input wire [31:0] regRdataFf,
  input wire memRdFf,
  input wire memWrFf,
  input wire [31:0] memAddrFf,
  input wire [63:0] memWdataFf,
  input wire memAck,
  input wire busyFf,
  input wire doneFf
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [31:0] prevWr;
  logic prevOk;
  // last written address of the running descriptor
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prevOk <= 1'b0;
      prevWr <= 32'h0;
    end else if (!busyFf) begin
      prevOk <= 1'b0;
    end else if (memWrFf && memAck) begin
      prevOk <= 1'b1;
      prevWr <= memAddrFf;
    end
  end
  sequence s_rdWait; memRdFf && !memAck; endsequence
  sequence s_wrWait; memWrFf && !memAck; endsequence
  sequence s_ackd; (memRdFf || memWrFf) && memAck; endsequence
  property p_rd_hold; s_rdWait |=> memRdFf && $stable(memAddrFf); endproperty
  property p_wr_hold;
    s_wrWait |=> memWrFf && $stable(memAddrFf) && $stable(memWdataFf);
  endproperty
  property p_drop; s_ackd |=> !memRdFf && !memWrFf; endproperty
  property p_excl; !(memRdFf && memWrFf); endproperty
  property p_idle; !busyFf |-> !memRdFf && !memWrFf; endproperty
  property p_done; $fell(busyFf) |-> doneFf; endproperty
  property p_start;
    regWr && regAddr == `OFF_ACCEL_CTRL && regWdata[`ACC_START_BIT] && !busyFf
      |-> ##[1:3] (busyFf || doneFf);
  endproperty
  property p_wr_step; $rose(memWrFf) && prevOk |-> memAddrFf == prevWr + 32'h8; endproperty
  property p_rd_zero; !regRd |=> regRdataFf == 32'h0; endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read request moved before ack");
  a_wr_hold: assert property (p_wr_hold) else $error("write request moved before ack");
  a_drop: assert property (p_drop) else $error("request kept after ack");
  a_excl: assert property (p_excl) else $error("read and write at once");
  a_idle: assert property (p_idle) else $error("memory traffic while idle");
  a_done: assert property (p_done) else $error("busy fell without done");
  a_start: assert property (p_start) else $error("start not taken");
  a_wr_step: assert property (p_wr_step) else $error("result units out of order");
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
endmodule // raid_xor_monitor
bind raid_xor_gf_accumulator raid_xor_monitor u_raid_xor_monitor (.sys_clk, .rstn, .regAddr,
  .regWdata, .regWr, .regRd, .regRdataFf, .memRdFf, .memWrFf, .memAddrFf, .memWdataFf,
  .memAck, .busyFf, .doneFf);

// file: test/mem_model.sv
// local memory model: one memAck pulse per held request after lag cycles
// assumes read data is a fixed function of the address; writes are recorded
`timescale 1ns/10ps
module mem_model (
  input wire sys_clk,
  input wire memRdFf,
  input wire memWrFf,
  input wire [31:0] memAddrFf,
  input wire [63:0] memWdataFf,
  input wire [3:0] lag,
  input wire clr,
  output logic memAck,
  output logic [63:0] memRdata
);
  logic [63:0] wmem [int unsigned];
  int nWr = 0;
  int nRd = 0;
  int cnt = 0;
  initial begin
    memAck = 1'b0;
    memRdata = 64'h0;
  end
  always @(posedge sys_clk) begin
    memAck <= 1'b0;
    if (clr) begin
      wmem.delete();
      nWr <= 0;
      nRd <= 0;
    end
    // data lines toggle when no read is answered
    memRdata <= ~memRdata;
    if ((memRdFf || memWrFf) && !memAck) begin
      cnt <= cnt + 1;
      if (cnt >= lag) begin
        memAck <= 1'b1;
        cnt <= 0;
        if (memRdFf) begin
          memRdata <= {memAddrFf, memAddrFf ^ 32'h5ac3_96e1};
          nRd <= nRd + 1;
        end else begin
          wmem[memAddrFf] = memWdataFf;
          nWr <= nWr + 1;
        end
      end
    end
  end
endmodule // mem_model

// file: test/tb.sv
// testbench of the parity accumulator against the local memory model
// assumes 40 MHz clock and a register port with read data one cycle later
`timescale 1ns/10ps
`include "raid_xor_map.vh"
module tb;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] regAddr = 8'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [3:0] lag = 4'h0;
  logic clr = 1'b0;
  logic [31:0] v;
  wire [31:0] regRdataFf;
  wire [31:0] memAddrFf;
  wire [63:0] memWdataFf;
  wire [63:0] memRdata;
  wire memRdFf, memWrFf, memAck, busyFf, doneFf;
  int num_errors = 0;
  int n_tests = 0;
  raid_xor_gf_accumulator u_raid_xor_gf_accumulator (.sys_clk(sys_clk), .rstn(rstn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdataFf(regRdataFf), .memRdFf(memRdFf), .memWrFf(memWrFf), .memAddrFf(memAddrFf),
    .memWdataFf(memWdataFf), .memAck(memAck), .memRdata(memRdata), .busyFf(busyFf),
    .doneFf(doneFf));
  mem_model u_mem_model (.sys_clk(sys_clk), .memRdFf(memRdFf), .memWrFf(memWrFf),
    .memAddrFf(memAddrFf), .memWdataFf(memWdataFf), .lag(lag), .clr(clr), .memAck(memAck),
    .memRdata(memRdata));
  initial forever #12.5 sys_clk = ~sys_clk;
  task check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdataFf;
  endtask
  function automatic logic [63:0] md(input logic [31:0] a);
    return {a, a ^ 32'h5ac3_96e1};
  endfunction
  // shift-and-add field multiply, reduced by the low byte of 0x11d
  function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h0;
    for (int i = 0; i < 8; i++) begin
      if (b[i])
        p = p ^ a;
      a = a[7] ? ((a << 1) ^ 8'h1d) : (a << 1);
    end
    return p;
  endfunction
  function automatic logic [63:0] lanes(input logic [63:0] d, input logic [7:0] c);
    for (int i = 0; i < 8; i++)
      d[8*i +: 8] = gm(d[8*i +: 8], c);
    return d;
  endfunction
  task run(input logic [31:0] acc, input logic [31:0] dc, input logic [31:0] cnt);
    int i;
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    wr(`OFF_DESC_CTRL, dc);
    wr(`OFF_BYTE_COUNT, cnt);
    wr(`OFF_ACCEL_CTRL, acc | 32'h1);
    i = 0;
    while (doneFf !== 1'b1 && i < 20000) begin
      @(posedge sys_clk);
      i++;
    end
    if (i >= 20000) begin
      num_errors++;
      test_done;
    end
    wr(`OFF_STATUS, 32'h2);
    rd(`OFF_STATUS, v);
    check(v, 32'h0);
  endtask
  task t_reset;
    rd(`OFF_DESC_CTRL, v);
    check(v, `RST_DESC_CTRL);
    rd(`OFF_ACCEL_CTRL, v);
    check(v, `RST_ACCEL_CTRL);
    rd(8'h30, v);
    check(v, 32'h0);
    $display("reset test ended");
  endtask
  task t_xor4;
    lag = 4'h3;
    run(32'h0, 32'hf, 32'h10);
    check(u_mem_model.nWr, 2);
    for (int u = 0; u < 2; u++)
      check(u_mem_model.wmem[32'h8000 + 8*u], md(32'h1000 + 8*u) ^ md(32'h2000 + 8*u)
        ^ md(32'h3000 + 8*u) ^ md(32'h4000 + 8*u));
    lag = 4'h0;
    $display("xor test ended");
  endtask
  task t_pq;
    wr(`OFF_COEF, 32'h0007_0203);
    run(32'h1 << `ACC_PQ_BIT, 32'hf, 32'h8);
    check(u_mem_model.wmem[32'h8000], lanes(md(32'h1000), 8'h03) ^ lanes(md(32'h2000), 8'h02)
      ^ lanes(md(32'h3000), 8'h07));
    wr(`OFF_COEF, 32'h0101_0101);
    run(32'h1 << `ACC_PQ_BIT, 32'hf, 32'h8);
    check(u_mem_model.wmem[32'h8000], md(32'h1000) ^ md(32'h2000) ^ md(32'h3000)
      ^ md(32'h4000));
    wr(`OFF_COEF, 32'h0);
    $display("pq test ended");
  endtask
  task t_big;
    run(32'h1 << `ACC_BUF512_BIT, 32'h3, 32'h208);
    check(u_mem_model.nWr, 65);
    check(u_mem_model.nRd, 65);
    check(u_mem_model.wmem[32'h8200], md(32'h1200));
    rd(`OFF_REMAIN, v);
    check(v, 32'h0);
    $display("multi buffer test ended");
  endtask
  task t_nodwe;
    run(32'h1 << `ACC_BUF512_BIT, 32'h1, 32'h208);
    check(u_mem_model.nWr, 0);
    check(u_mem_model.nRd, 64);
    rd(`OFF_REMAIN, v);
    check(v, 32'h8);
    wr(`OFF_SRC1, 32'h2000);
    run(32'h0, 32'h2, 32'h8);
    check(u_mem_model.wmem[32'h8000], md(32'h1000) ^ md(32'h2000));
    $display("held queue test ended");
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset;
    for (int k = 0; k < 4; k++)
      wr(`OFF_SRC1 + 8'h4 * k, 32'h1000 * (k + 1));
    wr(`OFF_DEST, 32'h8000);
    t_xor4;
    t_pq;
    t_big;
    t_nodwe;
    test_done;
  end
endmodule // tb
